// file: common/pdo_map.vh
/*
  register offsets, field positions, reset values and override
  constants for the port override block; definitions only.
*/
`ifndef PDO_MAP_VH
`define PDO_MAP_VH

// register word indices (byte address is four times the index)
`define PDO_IDX_PA_LATCH 4'h0
`define PDO_IDX_PA_DIR 4'h1
`define PDO_IDX_PA_PINS 4'h2
`define PDO_IDX_PB_LATCH 4'h3
`define PDO_IDX_PB_DIR 4'h4
`define PDO_IDX_PB_PINS 4'h5
`define PDO_IDX_PD_LATCH 4'h6
`define PDO_IDX_PD_DIR 4'h7
`define PDO_IDX_PD_PINS 4'h8
`define PDO_IDX_CTRL 4'h9
`define PDO_IDX_FUNC 4'hA

// implemented bit masks
`define PDO_PA_MASK 8'h07
`define PDO_PB_MASK 8'hFF
`define PDO_PD_MASK 8'h7F

// reset values
`define PDO_LATCH_RST 8'h00
`define PDO_DIR_RST 8'h00
`define PDO_CTRL_RST 8'h00

// control register fields
`define PDO_CTRL_PUD 0
`define PDO_CTRL_TIMER0_CLOCK_SELECT_MID 1
`define PDO_CTRL_TIMER0_CLOCK_SELECT_HI 2

// pin-function register fields (peripheral enables)
`define PDO_FN_TX_EN 0
`define PDO_FN_RX_EN 1
`define PDO_FN_XCK_OUT 2
`define PDO_FN_XCK_IN 3
`define PDO_FN_SYSTEM_CLOCK_OUTPUT 4
`define PDO_FN_EXT_INTERRUPT_ZERO 5
`define PDO_FN_EXT_INTERRUPT_ONE 6
`define PDO_FN_T1 7
`define PDO_FN_ICP 8
`define PDO_FN_CMPB 9
`define PDO_FN_SYNC 10
`define PDO_FN_W 11

// port D bit positions
`define PDO_D_RXD 0
`define PDO_D_TXD 1
`define PDO_D_XCK 2
`define PDO_D_EXT_INTERRUPT_ONE 3
`define PDO_D_T0 4
`define PDO_D_T1 5
`define PDO_D_ICP 6

`endif

// file: logic/pdo_pin_cell.v
/*
  one port pin: merges override signals with the port registers and
  produces pad output, output enable, pull-up and sampled input.
  assumes inputs synchronous to the clock; pad is sampled twice.
*/
`timescale 1ns/100ps
module pdo_pin_cell (
  input wire i_clk,
  input wire i_rst,
  input wire i_latch,
  input wire i_dir,
  input wire i_pud,
  input wire i_pullup_override_enable,
  input wire i_pullup_override_value,
  input wire i_direction_override_enable,
  input wire i_direction_override_value,
  input wire i_port_value_override_enable,
  input wire i_port_value_override_value,
  input wire i_input_enable_override_enable,
  input wire i_input_enable_override_value,
  input wire i_sleep,
  input wire i_pad,
  output wire o_pad,
  output wire o_pad_oe,
  output wire o_pullup,
  output wire o_din
);
  // effective direction, value and input enable after override
  wire dir_eff;
  wire val_eff;
  wire die_eff;
  reg sync1_q;
  reg sync2_q;

  assign dir_eff = i_direction_override_enable ? i_direction_override_value : i_dir;
  assign val_eff = i_port_value_override_enable ? i_port_value_override_value : i_latch;
  // normal pull-up: input, latch high, not globally disabled
  assign o_pullup = i_pullup_override_enable ? i_pullup_override_value : (~dir_eff & i_latch & ~i_pud);
  assign o_pad = val_eff;
  assign o_pad_oe = dir_eff;
  // digital input gated only in sleep unless an override forces it on
  assign die_eff = i_input_enable_override_enable ? i_input_enable_override_value : ~i_sleep;

  // two-stage sampler; first stage feeds only the second
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= i_pad & die_eff;
      sync2_q <= sync1_q;
    end
  end
  assign o_din = sync2_q;
endmodule // pdo_pin_cell

// file: logic/pdo_port_ctrl.v
/*
  port A/B/D registers with Port D alternate function overrides,
  reached over an Avalon-MM slave with waitrequest.
  assumes peripherals supply their enables and outputs synchronously.
*/
`timescale 1ns/100ps
`include "pdo_map.vh"
module pdo_port_ctrl (
  input wire I_CLK,
  input wire I_SYS_RST,
  // avalon-mm slave
  input wire [5:0] I_AVS_ADDRESS,
  input wire I_AVS_READ,
  input wire I_AVS_WRITE,
  input wire [31:0] I_AVS_WRITEDATA,
  input wire [3:0] I_AVS_BYTEENABLE,
  output wire [31:0] O_AVS_READDATA,
  output wire O_AVS_WAITREQUEST,
  output wire [1:0] O_AVS_RESPONSE,
  // peripheral side
  input wire I_TX_DATA,
  input wire I_XCK_OUT,
  input wire I_SYS_CLK_LEVEL,
  input wire I_CMPB_VALUE,
  input wire I_SLEEP,
  output wire O_RX_DATA,
  output wire O_XCK_IN,
  output wire O_TIMER0_CLK,
  output wire O_TIMER1_CLK,
  output wire O_CAPTURE_IN,
  output wire O_EXT_INTERRUPT_ZERO_IN,
  output wire O_EXT_INTERRUPT_ONE_IN,
  // pads
  input wire [2:0] I_PA_PAD,
  input wire [7:0] I_PB_PAD,
  input wire [6:0] I_PD_PAD,
  output wire [2:0] O_PA_PAD,
  output wire [2:0] O_PA_OE,
  output wire [2:0] O_PA_PULLUP,
  output wire [7:0] O_PB_PAD,
  output wire [7:0] O_PB_OE,
  output wire [7:0] O_PB_PULLUP,
  output wire [6:0] O_PD_PAD,
  output wire [6:0] O_PD_OE,
  output wire [6:0] O_PD_PULLUP
);
  // port registers
  reg [2:0] pa_latch_q;
  reg [2:0] pa_dir_q;
  reg [7:0] pb_latch_q;
  reg [7:0] pb_dir_q;
  reg [6:0] pd_latch_q;
  reg [6:0] pd_dir_q;
  reg [2:0] ctrl_q; // timer select bits and pull-up disable for every pin but pd0 under the receiver, whose pull-up it enables
  reg [`PDO_FN_W-1:0] func_q; // peripheral pin-function enables
  // answer path
  reg ack_q; // one-cycle answer phase
  reg [31:0] rdata_q;
  reg [1:0] resp_q;
  reg [31:0] rdata_d;
  reg hit_d;
  // sampled pad levels
  wire [2:0] pa_din;
  wire [7:0] pb_din;
  wire [6:0] pd_din;
  // port D override vectors
  reg [6:0] pullup_override_enable;
  reg [6:0] pullup_override_value;
  reg [6:0] direction_override_enable;
  reg [6:0] direction_override_value;
  reg [6:0] port_value_override_enable;
  reg [6:0] port_value_override_value;
  reg [6:0] input_enable_override_enable;
  wire global_pullup_disable;
  wire t0_sel;
  wire tx_en;
  wire rx_en;
  wire xck_drv;
  wire xck_rx;
  wire req;
  wire [3:0] idx;
  // merged write bytes, masked; the registers keep only their low bits
  wire [7:0] pa_latch_nx;
  wire [7:0] pa_dir_nx;
  wire [7:0] pd_latch_nx;
  wire [7:0] pd_dir_nx;

  assign global_pullup_disable = ctrl_q[`PDO_CTRL_PUD];
  assign t0_sel = ctrl_q[`PDO_CTRL_TIMER0_CLOCK_SELECT_HI] & ctrl_q[`PDO_CTRL_TIMER0_CLOCK_SELECT_MID];
  assign tx_en = func_q[`PDO_FN_TX_EN];
  assign rx_en = func_q[`PDO_FN_RX_EN];
  // transfer clock used only in synchronous mode
  assign xck_drv = func_q[`PDO_FN_SYNC] & func_q[`PDO_FN_XCK_OUT];
  assign xck_rx = func_q[`PDO_FN_SYNC] & func_q[`PDO_FN_XCK_IN];

  // byte-lane merge for the low lane; of the other lanes only lane 1 holds data, for the function register
  function [7:0] lane0;
    input [7:0] old_v;
    input [31:0] wd;
    input [3:0] be;
    begin
      lane0 = be[0] ? wd[7:0] : old_v;
    end
  endfunction

  // word index decode: true for every index up to the function register; alignment is not checked here
  function mapped;
    input [3:0] ix;
    begin
      mapped = (ix <= `PDO_IDX_FUNC);
    end
  endfunction

  // byte merge masked to the implemented bits, cut on store
  assign pa_latch_nx = lane0({5'h00, pa_latch_q}, I_AVS_WRITEDATA,
                             I_AVS_BYTEENABLE) & `PDO_PA_MASK;
  assign pa_dir_nx = lane0({5'h00, pa_dir_q}, I_AVS_WRITEDATA,
                           I_AVS_BYTEENABLE) & `PDO_PA_MASK;
  assign pd_latch_nx = lane0({1'b0, pd_latch_q}, I_AVS_WRITEDATA,
                             I_AVS_BYTEENABLE) & `PDO_PD_MASK;
  assign pd_dir_nx = lane0({1'b0, pd_dir_q}, I_AVS_WRITEDATA,
                           I_AVS_BYTEENABLE) & `PDO_PD_MASK;

  // a request is answered the cycle after it is seen
  assign req = (I_AVS_READ | I_AVS_WRITE) & ~ack_q;
  assign idx = I_AVS_ADDRESS[5:2];
  assign O_AVS_WAITREQUEST = ~ack_q;
  assign O_AVS_READDATA = rdata_q;
  assign O_AVS_RESPONSE = resp_q;

  // read mux; unimplemented bits read as zero
  always @* begin
    rdata_d = 32'h0000_0000;
    hit_d = mapped(idx);
    case (idx)
      `PDO_IDX_PA_LATCH: rdata_d[2:0] = pa_latch_q;
      `PDO_IDX_PA_DIR: rdata_d[2:0] = pa_dir_q;
      `PDO_IDX_PA_PINS: rdata_d[2:0] = pa_din;
      `PDO_IDX_PB_LATCH: rdata_d[7:0] = pb_latch_q;
      `PDO_IDX_PB_DIR: rdata_d[7:0] = pb_dir_q;
      `PDO_IDX_PB_PINS: rdata_d[7:0] = pb_din;
      `PDO_IDX_PD_LATCH: rdata_d[6:0] = pd_latch_q;
      `PDO_IDX_PD_DIR: rdata_d[6:0] = pd_dir_q;
      `PDO_IDX_PD_PINS: rdata_d[6:0] = pd_din;
      `PDO_IDX_CTRL: rdata_d[2:0] = ctrl_q;
      `PDO_IDX_FUNC: rdata_d[`PDO_FN_W-1:0] = func_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // bus answer and register writes; write lands on the answer edge
  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      resp_q <= 2'h0;
      pa_latch_q <= 3'h0;
      pa_dir_q <= 3'h0;
      pb_latch_q <= `PDO_LATCH_RST;
      pb_dir_q <= `PDO_DIR_RST;
      pd_latch_q <= 7'h00;
      pd_dir_q <= 7'h00;
      ctrl_q <= 3'h0;
      func_q <= {`PDO_FN_W{1'b0}};
    end else begin
      ack_q <= req;
      if (req) begin
        // unmapped or misaligned: slave error; unmapped words read zero, misaligned reads return the register
        resp_q <= (hit_d && I_AVS_ADDRESS[1:0] == 2'h0) ? 2'h0 : 2'h2;
        rdata_q <= I_AVS_READ ? rdata_d : 32'h0000_0000;
      end
      // write lands on the edge where the master sees waitrequest low
      if (ack_q && I_AVS_WRITE && I_AVS_ADDRESS[1:0] == 2'h0) begin
        case (idx)
          `PDO_IDX_PA_LATCH:
            pa_latch_q <= pa_latch_nx[2:0];
          `PDO_IDX_PA_DIR:
            pa_dir_q <= pa_dir_nx[2:0];
          `PDO_IDX_PB_LATCH:
            pb_latch_q <= lane0(pb_latch_q, I_AVS_WRITEDATA,
                                I_AVS_BYTEENABLE);
          `PDO_IDX_PB_DIR:
            pb_dir_q <= lane0(pb_dir_q, I_AVS_WRITEDATA,
                              I_AVS_BYTEENABLE);
          `PDO_IDX_PD_LATCH:
            pd_latch_q <= pd_latch_nx[6:0];
          `PDO_IDX_PD_DIR:
            pd_dir_q <= pd_dir_nx[6:0];
          `PDO_IDX_CTRL:
            if (I_AVS_BYTEENABLE[0]) begin
              ctrl_q <= I_AVS_WRITEDATA[2:0];
            end
          `PDO_IDX_FUNC: begin
            if (I_AVS_BYTEENABLE[0]) begin
              func_q[7:0] <= I_AVS_WRITEDATA[7:0];
            end
            if (I_AVS_BYTEENABLE[1]) begin
              func_q[`PDO_FN_W-1:8] <= I_AVS_WRITEDATA[`PDO_FN_W-1:8];
            end
          end
          default: begin
            // pin registers and holes ignore writes
          end
        endcase
      end
    end
  end

  // port D override table
  always @* begin
    pullup_override_enable = 7'h00;
    pullup_override_value = 7'h00;
    direction_override_enable = 7'h00;
    direction_override_value = 7'h00;
    port_value_override_enable = 7'h00;
    port_value_override_value = 7'h00;
    input_enable_override_enable = 7'h00;
    pullup_override_enable[`PDO_D_RXD] = rx_en;
    pullup_override_value[`PDO_D_RXD] = pd_latch_q[`PDO_D_RXD] & global_pullup_disable;
    direction_override_enable[`PDO_D_RXD] = rx_en;
    direction_override_value[`PDO_D_RXD] = 1'b0;
    pullup_override_enable[`PDO_D_TXD] = tx_en;
    pullup_override_value[`PDO_D_TXD] = 1'b0;
    direction_override_enable[`PDO_D_TXD] = tx_en;
    direction_override_value[`PDO_D_TXD] = 1'b1;
    port_value_override_enable[`PDO_D_TXD] = tx_en;
    port_value_override_value[`PDO_D_TXD] = I_TX_DATA;
    // transfer clock output has priority over clock output
    // system clock on pd2 when transfer clock idle
    port_value_override_enable[`PDO_D_XCK] = xck_drv | func_q[`PDO_FN_SYSTEM_CLOCK_OUTPUT];
    port_value_override_value[`PDO_D_XCK] = xck_drv ? I_XCK_OUT : I_SYS_CLK_LEVEL;
    // interrupts force inputs on, clock input too
    input_enable_override_enable[`PDO_D_XCK] = func_q[`PDO_FN_EXT_INTERRUPT_ZERO] | xck_rx;
    input_enable_override_enable[`PDO_D_EXT_INTERRUPT_ONE] = func_q[`PDO_FN_EXT_INTERRUPT_ONE];
    // timer and capture inputs, compare b value
    input_enable_override_enable[`PDO_D_T0] = t0_sel;
    input_enable_override_enable[`PDO_D_T1] = func_q[`PDO_FN_T1];
    input_enable_override_enable[`PDO_D_ICP] = func_q[`PDO_FN_ICP];
    port_value_override_enable[`PDO_D_T1] = func_q[`PDO_FN_CMPB];
    port_value_override_value[`PDO_D_T1] = I_CMPB_VALUE;
  end

  // per-pin cells; direction one enables the driver
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pa
      pdo_pin_cell u_cell (
        .i_clk(I_CLK), .i_rst(I_SYS_RST),
        .i_latch(pa_latch_q[g]), .i_dir(pa_dir_q[g]), .i_pud(global_pullup_disable),
        .i_pullup_override_enable(1'b0), .i_pullup_override_value(1'b0), .i_direction_override_enable(1'b0), .i_direction_override_value(1'b0),
        .i_port_value_override_enable(1'b0), .i_port_value_override_value(1'b0), .i_input_enable_override_enable(1'b0), .i_input_enable_override_value(1'b0),
        .i_sleep(I_SLEEP), .i_pad(I_PA_PAD[g]),
        .o_pad(O_PA_PAD[g]), .o_pad_oe(O_PA_OE[g]),
        .o_pullup(O_PA_PULLUP[g]), .o_din(pa_din[g])
      );
    end
    for (g = 0; g < 8; g = g + 1) begin : g_pb
      pdo_pin_cell u_cell (
        .i_clk(I_CLK), .i_rst(I_SYS_RST),
        .i_latch(pb_latch_q[g]), .i_dir(pb_dir_q[g]), .i_pud(global_pullup_disable),
        .i_pullup_override_enable(1'b0), .i_pullup_override_value(1'b0), .i_direction_override_enable(1'b0), .i_direction_override_value(1'b0),
        .i_port_value_override_enable(1'b0), .i_port_value_override_value(1'b0), .i_input_enable_override_enable(1'b0), .i_input_enable_override_value(1'b0),
        .i_sleep(I_SLEEP), .i_pad(I_PB_PAD[g]),
        .o_pad(O_PB_PAD[g]), .o_pad_oe(O_PB_OE[g]),
        .o_pullup(O_PB_PULLUP[g]), .o_din(pb_din[g])
      );
    end
    for (g = 0; g < 7; g = g + 1) begin : g_pd
      pdo_pin_cell u_cell (
        .i_clk(I_CLK), .i_rst(I_SYS_RST),
        .i_latch(pd_latch_q[g]), .i_dir(pd_dir_q[g]), .i_pud(global_pullup_disable),
        .i_pullup_override_enable(pullup_override_enable[g]), .i_pullup_override_value(pullup_override_value[g]), .i_direction_override_enable(direction_override_enable[g]),
        .i_direction_override_value(direction_override_value[g]), .i_port_value_override_enable(port_value_override_enable[g]), .i_port_value_override_value(port_value_override_value[g]),
        .i_input_enable_override_enable(input_enable_override_enable[g]), .i_input_enable_override_value(1'b1),
        .i_sleep(I_SLEEP), .i_pad(I_PD_PAD[g]),
        .o_pad(O_PD_PAD[g]), .o_pad_oe(O_PD_OE[g]),
        .o_pullup(O_PD_PULLUP[g]), .o_din(pd_din[g])
      );
    end
  endgenerate

  // peripheral inputs; pd4 to timer0 only when selected
  assign O_TIMER0_CLK = pd_din[`PDO_D_T0] & t0_sel;
  assign O_TIMER1_CLK = pd_din[`PDO_D_T1];
  assign O_CAPTURE_IN = pd_din[`PDO_D_ICP];
  assign O_EXT_INTERRUPT_ZERO_IN = pd_din[`PDO_D_XCK];
  assign O_EXT_INTERRUPT_ONE_IN = pd_din[`PDO_D_EXT_INTERRUPT_ONE];
  assign O_XCK_IN = pd_din[`PDO_D_XCK];
  assign O_RX_DATA = pd_din[`PDO_D_RXD] & rx_en;
endmodule // pdo_port_ctrl

// file: tb/pdo_ctrl_props.sv
/* checker: bus answer timing, read-as-zero bits and pin timing
   of the port block; sees only its ports, bound at the foot */
`timescale 1ns/100ps
module pdo_ctrl_props (
  input wire I_CLK,
  input wire I_SYS_RST,
  input wire [5:0] I_AVS_ADDRESS,
  input wire I_AVS_READ,
  input wire I_AVS_WRITE,
  input wire [31:0] O_AVS_READDATA,
  input wire O_AVS_WAITREQUEST,
  input wire [1:0] O_AVS_RESPONSE,
  input wire [6:0] I_PD_PAD,
  input wire [2:0] O_PA_PAD,
  input wire [2:0] O_PA_OE,
  input wire [2:0] O_PA_PULLUP,
  input wire [6:0] O_PD_OE,
  input wire [6:0] O_PD_PULLUP,
  input wire O_TIMER0_CLK,
  input wire O_CAPTURE_IN
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // a new request is answered exactly one cycle later
  wait_low_a: assert property ($rose(I_AVS_READ || I_AVS_WRITE)
    |=> !O_AVS_WAITREQUEST) else $error("late answer");
  wait_one_a: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("answer too long");
  // unmapped words answer with an error and no data
  bad_addr_a: assert property (!O_AVS_WAITREQUEST
    && I_AVS_ADDRESS[5:2] > 4'hA |-> O_AVS_RESPONSE == 2'h2
    && O_AVS_READDATA == 32'h0) else $error("unmapped not refused");
  pa_zero_a: assert property (
    !O_AVS_WAITREQUEST && I_AVS_READ && I_AVS_ADDRESS[5:2] < 4'h3
    |-> O_AVS_READDATA[31:3] == 29'h0) else $error("port a high bits");
  pd_zero_a: assert property (
    !O_AVS_WAITREQUEST && I_AVS_READ && I_AVS_ADDRESS[5:2] > 4'h5
    && I_AVS_ADDRESS[5:2] < 4'h9 |-> O_AVS_READDATA[31:7] == 25'h0)
    else $error("port d bit 7");
  pull_in_a: assert property (
    (O_PD_PULLUP & O_PD_OE) == 7'h0 && (O_PA_PULLUP & O_PA_OE) == 3'h0)
    else $error("pull-up on a driven pin");
  // timer0 clock follows the sampled pin
  t0_clk_a: assert property (O_TIMER0_CLK |-> $past(I_PD_PAD[4], 2))
    else $error("timer0 clock without pin");
  // capture input follows the sampled pin
  cap_in_a: assert property (O_CAPTURE_IN |-> $past(I_PD_PAD[6], 2))
    else $error("capture without pin");
  // port a pins move only after a register write
  pa_write_a: assert property (
    $changed({O_PA_PAD, O_PA_OE, O_PA_PULLUP})
    |-> $past(I_AVS_WRITE && !O_AVS_WAITREQUEST))
    else $error("port a moved without write");
endmodule // pdo_ctrl_props

bind pdo_port_ctrl pdo_ctrl_props i_props (.I_CLK(I_CLK),
  .I_SYS_RST(I_SYS_RST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_RESPONSE(O_AVS_RESPONSE),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_PD_PAD(I_PD_PAD),
  .O_PA_PAD(O_PA_PAD), .O_PA_OE(O_PA_OE), .O_PA_PULLUP(O_PA_PULLUP),
  .O_PD_OE(O_PD_OE), .O_PD_PULLUP(O_PD_PULLUP),
  .O_TIMER0_CLK(O_TIMER0_CLK), .O_CAPTURE_IN(O_CAPTURE_IN));

// file: tb/pdo_pad_model.sv
/* pad model: outside drivers, pull-ups and floating pins
   assumes the bench chooses which pins it drives */
`timescale 1ns/100ps
module pdo_pad_model #(parameter int W = 8) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_oe,
  input wire logic [W-1:0] i_pu,
  input wire logic [W-1:0] i_ext,
  input wire logic [W-1:0] i_ext_en,
  output logic [W-1:0] o_lvl
);
  // a floating pin shows a changing level, never a stale one
  logic flt_q = 1'b0;
  always_ff @(posedge i_clk) flt_q <= ~flt_q;
  // device driver wins, then outside driver, then pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (i_oe[i]) o_lvl[i] = i_out[i];
      else if (i_ext_en[i]) o_lvl[i] = i_ext[i];
      else o_lvl[i] = i_pu[i] | flt_q;
    end
  end
endmodule // pdo_pad_model

// file: tb/test_pdo_port_ctrl.sv
/* bench for the port block: bus tasks, pad models, scenarios
   assumes every bus request is answered within 50 cycles */
`timescale 1ns/100ps
module test_pdo_port_ctrl;
  logic clk = 0;
  logic rst = 1;
  logic [5:0] adr = 6'h00;
  logic rd = 0, wr = 0, tx = 0, xo = 0, sck = 0, cmp = 0, slp = 0;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0] rsp;
  logic [7:0] ext = 8'h00;
  logic [7:0] ext_en = 8'hFF;
  logic [3:0] be = 4'h3;
  wire [31:0] o_rd;
  wire [1:0] o_rsp;
  wire o_wq, o_rx, o_xin, o_t0, o_t1, o_cap, o_i0, o_i1;
  wire [2:0] pa_o, pa_oe, pa_pu, pa_l;
  wire [7:0] pb_o, pb_oe, pb_pu, pb_l;
  wire [6:0] pd_o, pd_oe, pd_pu, pd_l;
  int mismatches = 0, tests_run = 0;
  // byte enables driven by the bench; registers sit in the low lanes
  pdo_port_ctrl i_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_AVS_ADDRESS(adr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
    .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(o_rd),
    .O_AVS_WAITREQUEST(o_wq), .O_AVS_RESPONSE(o_rsp), .I_TX_DATA(tx),
    .I_XCK_OUT(xo), .I_SYS_CLK_LEVEL(sck), .I_CMPB_VALUE(cmp),
    .I_SLEEP(slp), .O_RX_DATA(o_rx), .O_XCK_IN(o_xin), .O_TIMER0_CLK(o_t0),
    .O_TIMER1_CLK(o_t1), .O_CAPTURE_IN(o_cap), .O_EXT_INTERRUPT_ZERO_IN(o_i0),
    .O_EXT_INTERRUPT_ONE_IN(o_i1), .I_PA_PAD(pa_l), .I_PB_PAD(pb_l), .I_PD_PAD(pd_l),
    .O_PA_PAD(pa_o), .O_PA_OE(pa_oe), .O_PA_PULLUP(pa_pu),
    .O_PB_PAD(pb_o), .O_PB_OE(pb_oe), .O_PB_PULLUP(pb_pu),
    .O_PD_PAD(pd_o), .O_PD_OE(pd_oe), .O_PD_PULLUP(pd_pu));
  pdo_pad_model #(.W(3)) i_pa (.i_clk(clk), .i_out(pa_o), .i_oe(pa_oe),
    .i_pu(pa_pu), .i_ext(ext[2:0]), .i_ext_en(ext_en[2:0]), .o_lvl(pa_l));
  pdo_pad_model #(.W(8)) i_pb (.i_clk(clk), .i_out(pb_o), .i_oe(pb_oe),
    .i_pu(pb_pu), .i_ext(ext), .i_ext_en(ext_en), .o_lvl(pb_l));
  pdo_pad_model #(.W(7)) i_pd (.i_clk(clk), .i_out(pd_o), .i_oe(pd_oe),
    .i_pu(pd_pu), .i_ext(ext[6:0]), .i_ext_en(ext_en[6:0]), .o_lvl(pd_l));
  always #2 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // one bus cycle: hold until waitrequest is seen low, then release
  task automatic bus(input logic w, input logic [3:0] ix,
      input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= {ix, 2'h0};
    wr <= w;
    rd <= ~w;
    wd <= {16'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (o_wq !== 1'b0 && n < 50);
    rdat = o_rd;
    rsp = o_rsp;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      wrap_up;
    end
  endtask
  task automatic look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // reset values, implemented bits, pin reads and an unmapped word
  task automatic t_regs;
    logic [7:0] m [3] = '{8'h07, 8'hFF, 8'h7F};
    for (int i = 0; i < 8; i++) begin
      if (i % 3 != 2) begin
        bus(0, i, 0);
        chk(rdat, 0);
        bus(1, i, 16'h00FF);
        bus(0, i, 0);
        chk(rdat, m[i / 3]);
        bus(1, i, 0);
      end
    end
    // lane 0 disabled: the write must leave the latch alone
    be <= 4'h0;
    bus(1, 0, 16'h0007);
    be <= 4'h3;
    bus(0, 0, 0);
    chk(rdat, 0);
    @(posedge clk);
    ext <= 8'hA5;
    look(3);
    bus(1, 2, 0);
    for (int i = 0; i < 3; i++) begin
      bus(0, 3 * i + 2, 0);
      chk(rdat, 8'hA5 & m[i]);
    end
    bus(0, 11, 0);
    chk({rsp, rdat[29:0]}, 32'h80000000);
  endtask
  // direction bits drive the pads, pull-ups on inputs only
  task automatic t_dir;
    bus(1, 1, 16'h0007);
    bus(1, 0, 16'h0005);
    bus(1, 4, 16'h00A5);
    bus(1, 3, 16'h003C);
    look(1);
    chk({pa_oe, pa_o, pb_oe, pb_o & pb_oe}, 22'h3DA524);
    chk(pb_pu, 8'h18);
    // outside drivers released: pulled pins read high, bare ones masked
    @(posedge clk);
    ext_en <= 8'h00;
    look(3);
    bus(0, 5, 0);
    chk(rdat & 32'hBD, 32'h3C);
    ext_en <= 8'hFF;
  endtask
  // transmitter takes pin 1 over: output, tx data, no pull-up
  task automatic t_tx;
    bus(1, 6, 16'h0003);
    look(1);
    chk(pd_pu[1], 1);
    bus(1, 10, 16'h0001);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      tx <= v[0];
      look(1);
      chk({pd_oe[1], pd_o[1], pd_pu[1]}, {1'b1, v[0], 1'b0});
    end
  endtask
  // receiver forces pin 0 to input and takes its level
  task automatic t_rx;
    bus(1, 7, 16'h0001);
    bus(1, 10, 16'h0002);
    for (int p = 0; p < 2; p++) begin
      bus(1, 9, p);
      look(3);
      chk({pd_oe[0], pd_pu[0], o_rx}, {1'b0, p[0], 1'b1});
    end
    @(posedge clk);
    ext <= 8'hA4;
    look(3);
    chk(o_rx, 0);
    bus(1, 9, 0);
  endtask
  // pin 2: transfer clock in sync mode, else system clock
  task automatic t_xck;
    @(posedge clk);
    xo <= 1'b1;
    bus(1, 7, 16'h0004);
    bus(1, 10, 16'h0404);
    look(1);
    chk(pd_o[2], 1);
    bus(1, 10, 16'h0014);
    look(1);
    chk(pd_o[2], 0);
    @(posedge clk);
    sck <= 1'b1;
    look(1);
    chk(pd_o[2], 1);
    bus(1, 7, 0);
    bus(1, 10, 16'h0408);
    @(posedge clk);
    slp <= 1'b1;
    look(3);
    chk(o_xin, 1);
  endtask
  // timer, capture and interrupt inputs stay on while asleep
  task automatic t_tmr;
    @(posedge clk);
    ext <= 8'h7C;
    bus(1, 10, 16'h01E0);
    bus(1, 9, 16'h0006);
    look(3);
    chk({o_t0, o_t1, o_cap, o_i0, o_i1}, 5'h1F);
    bus(1, 9, 16'h0002);
    bus(1, 10, 0);
    look(3);
    chk({o_t0, o_t1, o_cap, o_i0, o_i1}, 0);
    bus(1, 7, 16'h0020);
    bus(1, 10, 16'h0200);
    @(posedge clk);
    cmp <= 1'b1;
    look(1);
    chk({pd_oe[5], pd_o[5]}, 2'h3);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 10000 cycles
  initial begin
    #40000;
    mismatches++;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_dir;
    t_tx;
    t_rx;
    t_xck;
    t_tmr;
    wrap_up;
  end
endmodule // test_pdo_port_ctrl
